// ===== icsc_top.sv
// input clock select control: configuration registers 3 to 5 and their effects
// assumes a synchronous byte-wide configuration port behind the serial interface
//
// Behaviour
// - in manual mode with pin select off, the register choice field picks input one (00) or two (01).
// - in manual mode with pin select on, the choice pin picks the input and the register field is ignored.
// - the force hold bit puts the block in digital hold over every selection setting and input quality.
// - the squelch bit disables the output clocks during internal calibration when set, else leaves them on.
// - the method field selects manual, automatic non-revertive or automatic revertive selection.
// - the five-bit history delay field sets how far back the hold history is taken.
// - the two-bit drive field sets cmos output drive strength from 8 mA/5 mA up to 32 mA/20 mA.
// - reset loads 0x05, 0x12 and 0xED into the three registers.
// - automatic modes rank inputs by first and second priority codes, 00 for one and 01 for two.
`timescale 1ns/10ps
module icsc_top
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// configuration port
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	output logic [7:0] cfg_rdata,
	output logic cfg_rvalid,
	// selection pins and priorities
	input wire logic input_choice_pin,
	input wire logic pin_select_enable,
	input wire logic [1:0] first_priority_input,
	input wire logic [1:0] second_priority_input,
	// input quality and calibration state
	input wire logic input_one_valid,
	input wire logic input_two_valid,
	input wire logic internal_calibration,
	// results
	output logic active_input_two,
	output logic digital_hold,
	output logic output_clock_enable,
	output logic [4:0] history_delay,
	output logic [1:0] cmos_drive_strength
);

	logic [7:0] input_select_control;
	logic [7:0] selection_method_config;
	logic [7:0] cmos_drive_config;
	logic [7:0] next_input_select_control;
	logic [7:0] next_selection_method_config;
	logic [7:0] next_cmos_drive_config;
	logic [7:0] next_cfg_rdata;
	logic next_output_clock_enable;
	logic squelch_during_calibration;
	icsc_pkg::icsc_ctrl_t ctrl;
	icsc_pkg::icsc_status_t sel_status;

	// masked merge keeps reserved bits at reset value
	function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] wd, input logic [7:0] mask);
		merge = (cur & ~mask) | (wd & mask);
	endfunction

	// reserved bits must match their reset value
	function automatic logic fixed_ok(input logic [7:0] cur, input logic [7:0] rst, input logic [7:0] mask);
		fixed_ok = ((cur & ~mask) == (rst & ~mask));
	endfunction

	always_comb
	begin
		next_input_select_control = input_select_control;
		next_selection_method_config = selection_method_config;
		next_cmos_drive_config = cmos_drive_config;
		if (cfg_wr)
		begin
			case (cfg_addr)
				icsc_pkg::ICSC_ADDR_INPUT_SELECT:
					next_input_select_control = merge(input_select_control, cfg_wdata,
						icsc_pkg::ICSC_WMASK_INPUT_SELECT);
				icsc_pkg::ICSC_ADDR_METHOD:
					next_selection_method_config = merge(selection_method_config, cfg_wdata,
						icsc_pkg::ICSC_WMASK_METHOD);
				icsc_pkg::ICSC_ADDR_DRIVE:
					next_cmos_drive_config = merge(cmos_drive_config, cfg_wdata, icsc_pkg::ICSC_WMASK_DRIVE);
				default:
					next_cmos_drive_config = cmos_drive_config;
			endcase
		end
		// unmapped addresses read as zero
		case (cfg_addr)
			icsc_pkg::ICSC_ADDR_INPUT_SELECT:
				next_cfg_rdata = input_select_control;
			icsc_pkg::ICSC_ADDR_METHOD:
				next_cfg_rdata = selection_method_config;
			icsc_pkg::ICSC_ADDR_DRIVE:
				next_cfg_rdata = cmos_drive_config;
			default:
				next_cfg_rdata = 8'h00;
		endcase
		if (!cfg_rd)
			next_cfg_rdata = cfg_rdata;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			input_select_control <= icsc_pkg::ICSC_RST_INPUT_SELECT;
			selection_method_config <= icsc_pkg::ICSC_RST_METHOD;
			cmos_drive_config <= icsc_pkg::ICSC_RST_DRIVE;
			cfg_rdata <= 8'h00;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			input_select_control <= next_input_select_control;
			selection_method_config <= next_selection_method_config;
			cmos_drive_config <= next_cmos_drive_config;
			cfg_rdata <= next_cfg_rdata;
			cfg_rvalid <= cfg_rd;
		end
	end

	assign squelch_during_calibration = input_select_control[icsc_pkg::ICSC_SQUELCH_BIT];
	assign history_delay = selection_method_config[icsc_pkg::ICSC_HIST_LSB +: 5];
	assign cmos_drive_strength = cmos_drive_config[icsc_pkg::ICSC_DRIVE_LSB +: 2];

	always_comb
	begin
		ctrl.method = icsc_pkg::icsc_method_t'(selection_method_config[icsc_pkg::ICSC_METHOD_LSB +: 2]);
		ctrl.reg_choice = input_select_control[icsc_pkg::ICSC_CHOICE_LSB +: 2];
		ctrl.pin_en = pin_select_enable;
		ctrl.pin = input_choice_pin;
		ctrl.force_hold = input_select_control[icsc_pkg::ICSC_HOLD_BIT];
		ctrl.prio1 = first_priority_input;
		ctrl.prio2 = second_priority_input;
		// squelch only while calibration runs, so outputs return when it ends
		next_output_clock_enable = !(internal_calibration && squelch_during_calibration);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			output_clock_enable <= 1'b1;
		else
			output_clock_enable <= next_output_clock_enable;
	end

	icsc_selector u_selector
	(
		.mclk(mclk),
		.nrst(nrst),
		.ctrl(ctrl),
		.one_ok(input_one_valid),
		.two_ok(input_two_valid),
		.status(sel_status)
	);

	assign active_input_two = sel_status.use_two;
	assign digital_hold = sel_status.in_hold;

	// checks
	a_manual_reg_pick: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_MANUAL && !ctrl.pin_en && !ctrl.force_hold &&
		ctrl.reg_choice == icsc_pkg::ICSC_IN_TWO) |=> (active_input_two && !digital_hold))
		else $error("register choice not followed");
	a_manual_pin_pick: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_MANUAL && ctrl.pin_en && !ctrl.force_hold)
		|=> (active_input_two == $past(input_choice_pin)) && !digital_hold)
		else $error("choice pin not followed");
	a_force_hold_wins: assert property (@(posedge mclk) disable iff (!nrst)
		ctrl.force_hold |=> digital_hold)
		else $error("force hold ignored");
	a_squelch_cal: assert property (@(posedge mclk) disable iff (!nrst)
		(internal_calibration && squelch_during_calibration) |=> !output_clock_enable ##0
		(!$past(internal_calibration) || $past(squelch_during_calibration)))
		else $error("outputs not squelched in calibration");
	a_no_squelch: assert property (@(posedge mclk) disable iff (!nrst)
		!squelch_during_calibration |=> output_clock_enable)
		else $error("outputs disabled without squelch");
	a_revert_first: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_REVERT && !ctrl.force_hold &&
		ctrl.prio1 == icsc_pkg::ICSC_IN_ONE && input_one_valid) |=> (!active_input_two && !digital_hold))
		else $error("revertive mode left first priority");
	a_nonrev_stays: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_NONREVERT && !ctrl.force_hold && active_input_two &&
		!digital_hold && input_two_valid) |=> (active_input_two && !digital_hold))
		else $error("non-revertive mode switched away");
	a_both_bad_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method != icsc_pkg::ICSC_MANUAL && ctrl.method != icsc_pkg::ICSC_METHOD_RSVD &&
		!input_one_valid && !input_two_valid) |=> digital_hold)
		else $error("no hold with both inputs bad");
	a_hist_write: assert property (@(posedge mclk) disable iff (!nrst)
		(cfg_wr && cfg_addr == icsc_pkg::ICSC_ADDR_METHOD) |=> history_delay == $past(cfg_wdata[4:0]))
		else $error("history delay write lost");
	a_drive_write: assert property (@(posedge mclk) disable iff (!nrst)
		(cfg_wr && cfg_addr == icsc_pkg::ICSC_ADDR_DRIVE) |=> cmos_drive_strength == $past(cfg_wdata[7:6]))
		else $error("drive strength write lost");
	a_reset_values: assert property (@(posedge mclk) disable iff (!nrst)
		(!$past(nrst) && !$past(cfg_wr)) |-> (input_select_control == icsc_pkg::ICSC_RST_INPUT_SELECT &&
		selection_method_config == icsc_pkg::ICSC_RST_METHOD && cmos_drive_config == icsc_pkg::ICSC_RST_DRIVE))
		else $error("reset values wrong");
	a_reserved_fixed: assert property (@(posedge mclk) disable iff (!nrst)
		(fixed_ok(input_select_control, icsc_pkg::ICSC_RST_INPUT_SELECT, icsc_pkg::ICSC_WMASK_INPUT_SELECT) &&
		fixed_ok(selection_method_config, icsc_pkg::ICSC_RST_METHOD, icsc_pkg::ICSC_WMASK_METHOD) &&
		fixed_ok(cmos_drive_config, icsc_pkg::ICSC_RST_DRIVE, icsc_pkg::ICSC_WMASK_DRIVE)))
		else $error("reserved bits changed");
	a_read_reserved: assert property (@(posedge mclk) disable iff (!nrst)
		(cfg_rd && cfg_addr == icsc_pkg::ICSC_ADDR_DRIVE) |=> (cfg_rvalid &&
		fixed_ok(cfg_rdata, icsc_pkg::ICSC_RST_DRIVE, icsc_pkg::ICSC_WMASK_DRIVE)))
		else $error("reserved read bits wrong");
	a_manual_reserved: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_MANUAL && !ctrl.pin_en && !ctrl.force_hold && ctrl.reg_choice[1] &&
		!digital_hold) |=> ($stable(active_input_two) && !digital_hold))
		else $error("reserved register choice moved the input");
	a_method_reserved: assert property (@(posedge mclk) disable iff (!nrst)
		(ctrl.method == icsc_pkg::ICSC_METHOD_RSVD && !ctrl.force_hold) |=>
		($stable(active_input_two) && $stable(digital_hold)))
		else $error("reserved method changed the selection");

	c_revert_back: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl.method == icsc_pkg::ICSC_REVERT && active_input_two ##1 !active_input_two);
	c_auto_hold: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl.method == icsc_pkg::ICSC_NONREVERT && $rose(digital_hold));
	c_pin_mode: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl.pin_en && ctrl.method == icsc_pkg::ICSC_MANUAL && $rose(active_input_two));
	c_squelch: cover property (@(posedge mclk) disable iff (!nrst) $fell(output_clock_enable));
	c_prio_reserved: cover property (@(posedge mclk) disable iff (!nrst)
		ctrl.method == icsc_pkg::ICSC_REVERT && ctrl.prio1[1] && !digital_hold);

endmodule

// ===== icsc_pkg.sv
// constants, field layout and carrier types of the input clock select control
// assumes one 125 MHz clock domain and byte-wide configuration registers
package icsc_pkg;

	// register addresses on the configuration port
	localparam logic [7:0] ICSC_ADDR_INPUT_SELECT = 8'h03;
	localparam logic [7:0] ICSC_ADDR_METHOD = 8'h04;
	localparam logic [7:0] ICSC_ADDR_DRIVE = 8'h05;

	// values after reset
	localparam logic [7:0] ICSC_RST_INPUT_SELECT = 8'h05;
	localparam logic [7:0] ICSC_RST_METHOD = 8'h12;
	localparam logic [7:0] ICSC_RST_DRIVE = 8'hED;

	// writable bits; all others keep their reset value
	localparam logic [7:0] ICSC_WMASK_INPUT_SELECT = 8'hF0;
	localparam logic [7:0] ICSC_WMASK_METHOD = 8'hDF;
	localparam logic [7:0] ICSC_WMASK_DRIVE = 8'hC0;

	// field positions
	localparam int ICSC_CHOICE_LSB = 6;
	localparam int ICSC_HOLD_BIT = 5;
	localparam int ICSC_SQUELCH_BIT = 4;
	localparam int ICSC_METHOD_LSB = 6;
	localparam int ICSC_HIST_LSB = 0;
	localparam int ICSC_DRIVE_LSB = 6;

	// input codes used by register select and both priority fields
	localparam logic [1:0] ICSC_IN_ONE = 2'h0;
	localparam logic [1:0] ICSC_IN_TWO = 2'h1;

	typedef enum logic [1:0] {
		ICSC_MANUAL = 2'b00,
		ICSC_NONREVERT = 2'b01,
		ICSC_REVERT = 2'b10,
		ICSC_METHOD_RSVD = 2'b11
	} icsc_method_t;

	typedef enum logic [1:0] {
		ICSC_ST_ONE = 2'b00,
		ICSC_ST_TWO = 2'b01,
		ICSC_ST_HOLD = 2'b10
	} icsc_state_t;

	typedef struct packed {
		icsc_method_t method;
		logic [1:0] reg_choice;
		logic pin_en;
		logic pin;
		logic force_hold;
		logic [1:0] prio1;
		logic [1:0] prio2;
	} icsc_ctrl_t;

	typedef struct packed {
		logic use_two;
		logic in_hold;
	} icsc_status_t;

endpackage

// ===== icsc_selector.sv
// input clock selection state machine: manual, automatic and forced hold
// assumes control fields and input quality flags are synchronous to mclk
`timescale 1ns/10ps
module icsc_selector
(
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// control and input quality
	input wire icsc_pkg::icsc_ctrl_t ctrl,
	input wire logic one_ok,
	input wire logic two_ok,
	// selection result, registered
	output icsc_pkg::icsc_status_t status
);

	icsc_pkg::icsc_state_t state;
	icsc_pkg::icsc_state_t next_state;
	icsc_pkg::icsc_status_t next_status;
	logic [1:0] manual_choice;

	// reserved codes never count as a usable input
	function automatic logic code_ok(input logic [1:0] code, input logic ok1, input logic ok2);
		code_ok = (code == icsc_pkg::ICSC_IN_ONE) ? ok1 : ((code == icsc_pkg::ICSC_IN_TWO) ? ok2 : 1'b0);
	endfunction

	function automatic icsc_pkg::icsc_state_t code_state(input logic [1:0] code);
		code_state = (code == icsc_pkg::ICSC_IN_TWO) ? icsc_pkg::ICSC_ST_TWO : icsc_pkg::ICSC_ST_ONE;
	endfunction

	always_comb
	begin
		icsc_pkg::icsc_state_t ranked;
		ranked = icsc_pkg::ICSC_ST_HOLD;
		manual_choice = ctrl.pin_en ? {1'b0, ctrl.pin} : ctrl.reg_choice;
		if (code_ok(ctrl.prio1, one_ok, two_ok))
			ranked = code_state(ctrl.prio1);
		else if (code_ok(ctrl.prio2, one_ok, two_ok))
			ranked = code_state(ctrl.prio2);
		next_state = state;
		if (ctrl.force_hold)
			next_state = icsc_pkg::ICSC_ST_HOLD;
		else
		begin
			case (ctrl.method)
				icsc_pkg::ICSC_MANUAL:
				begin
					// manual ignores quality; a reserved code keeps the last choice
					if (code_ok(manual_choice, 1'b1, 1'b1))
						next_state = code_state(manual_choice);
				end
				icsc_pkg::ICSC_NONREVERT:
				begin
					if (!((state == icsc_pkg::ICSC_ST_ONE && one_ok) || (state == icsc_pkg::ICSC_ST_TWO && two_ok)))
						next_state = ranked;
				end
				icsc_pkg::ICSC_REVERT:
					next_state = ranked;
				default:
					next_state = state;
			endcase
		end
		next_status.in_hold = (next_state == icsc_pkg::ICSC_ST_HOLD);
		next_status.use_two = (next_state == icsc_pkg::ICSC_ST_HOLD) ? status.use_two :
			(next_state == icsc_pkg::ICSC_ST_TWO);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state <= icsc_pkg::ICSC_ST_ONE;
			status <= '0;
		end
		else
		begin
			state <= next_state;
			status <= next_status;
		end
	end

endmodule

// ===== icsc_src_model.sv
// behavioural model of the two upstream reference clock sources
// assumes the bench names the wanted quality of each input; lag makes a slow source
`timescale 1ns/10ps
module icsc_src_model
(
	// clock
	input wire logic mclk,
	// wanted quality {two, one} and response lag in cycles
	input wire logic [1:0] want,
	input wire logic [3:0] lag,
	// quality flags seen by the block
	output logic one_ok,
	output logic two_ok
);
	logic [3:0] cnt = 4'h0;
	initial one_ok = 1'b1;
	initial two_ok = 1'b1;
	// flags move on the falling edge so the block samples settled levels
	always @(negedge mclk)
	begin
		if (want !== {two_ok, one_ok} && cnt < lag)
			cnt <= cnt + 4'h1;
		else
		begin
			two_ok <= want[1];
			one_ok <= want[0];
			cnt <= 4'h0;
		end
	end
endmodule

// ===== icsc_top_tb.sv
// self-checking bench of the input clock select control
// assumes the byte-wide configuration port and one 125 MHz clock
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module icsc_top_tb;
	logic mclk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, pin = 1'b0, pin_en = 1'b0, cal = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, shadow [3];
	logic rvalid, one_ok, two_ok, in_two, hold, oce;
	logic [1:0] prio1 = 2'h0, prio2 = 2'h1, drive, want = 2'h3;
	logic [3:0] lag = 4'h0;
	logic [4:0] hist;
	logic [31:0] seed = 32'hA942, r;
	int mismatches = 0, tests_run = 0;
	always #4 mclk = ~mclk;
	icsc_src_model SRC (.mclk(mclk), .want(want), .lag(lag), .one_ok(one_ok), .two_ok(two_ok));
	icsc_top DUT (.mclk(mclk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(addr),
		.cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .input_choice_pin(pin),
		.pin_select_enable(pin_en), .first_priority_input(prio1), .second_priority_input(prio2),
		.input_one_valid(one_ok), .input_two_valid(two_ok), .internal_calibration(cal),
		.active_input_two(in_two), .digital_hold(hold), .output_clock_enable(oce),
		.history_delay(hist), .cmos_drive_strength(drive));
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] wm(input logic [7:0] a);
		case (a)
			8'h03: return icsc_pkg::ICSC_WMASK_INPUT_SELECT;
			8'h04: return icsc_pkg::ICSC_WMASK_METHOD;
			8'h05: return icsc_pkg::ICSC_WMASK_DRIVE;
			default: return 8'h00;
		endcase
	endfunction
	// one-cycle strobes, raised and dropped on falling edges
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		cfg_wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge mclk);
		cfg_wr = 1'b0;
		if (wm(a) !== 8'h00)
			shadow[a - 8'h03] = (shadow[a - 8'h03] & ~wm(a)) | (d & wm(a));
	endtask
	task rd_chk(input logic [7:0] a);
		@(negedge mclk);
		cfg_rd = 1'b1;
		addr = a;
		@(negedge mclk);
		cfg_rd = 1'b0;
		`CHK(rvalid, 1'b1)
		`CHK(rdata, (wm(a) !== 8'h00) ? shadow[a - 8'h03] : 8'h00)
	endtask
	// register write lands one edge, selection follows on the next
	task settle();
		repeat (2) @(negedge mclk);
	endtask
	task src(input logic [1:0] w);
		want = w;
		repeat (lag + 4) @(negedge mclk);
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	// reset held 8 cycles; outputs checked at release while still at reset values
	task do_reset();
		nrst = 1'b0;
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		shadow = '{icsc_pkg::ICSC_RST_INPUT_SELECT, icsc_pkg::ICSC_RST_METHOD, icsc_pkg::ICSC_RST_DRIVE};
		`CHK(hist, 5'h12)
		`CHK(drive, 2'h3)
		`CHK({in_two, hold, oce}, 3'h1)
	endtask
	task close_out();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge mclk);
		mismatches++;
		close_out();
	end
	initial
	begin
		do_reset();
		for (int a = 2; a < 7; a++) rd_chk(a[7:0]);
		done("reset");
		for (int a = 3; a < 6; a++)
		begin
			wr(a[7:0], 8'hFF);
			rd_chk(a[7:0]);
		end
		wr(8'h07, 8'hFF);
		rd_chk(8'h07);
		wr(8'h03, 8'h00);
		repeat (6)
		begin
			r = rnd();
			wr(8'h04, {2'h0, r[5:0]});
			wr(8'h05, r[15:8]);
			settle();
			`CHK(hist, r[4:0])
			`CHK(drive, r[15:14])
			rd_chk(8'h05);
		end
		done("fields");
		// 10 is reserved: the previous choice must survive it
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h03, {2'(i % 3), 6'h00});
			settle();
			`CHK(in_two, (i == 1 || i == 2) ? 1'b1 : 1'b0)
		end
		pin_en = 1'b1;
		wr(8'h03, 8'h40);
		repeat (4)
		begin
			r = rnd();
			pin = r[0];
			settle();
			`CHK(in_two, r[0])
		end
		pin_en = 1'b0;
		done("manual");
		wr(8'h03, 8'h20);
		settle();
		`CHK(hold, 1'b1)
		wr(8'h04, 8'h92);
		settle();
		`CHK(hold, 1'b1)
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h12);
		settle();
		`CHK(hold, 1'b0)
		cal = 1'b1;
		settle();
		`CHK(oce, 1'b1)
		wr(8'h03, 8'h10);
		settle();
		`CHK(oce, 1'b0)
		cal = 1'b0;
		settle();
		`CHK(oce, 1'b1)
		done("hold and squelch");
		// slow sources in the revertive part
		lag = 4'h2;
		wr(8'h04, 8'h92);
		src(2'b10);
		`CHK(in_two, 1'b1)
		src(2'b11);
		`CHK(in_two, 1'b0)
		src(2'b00);
		`CHK(hold, 1'b1)
		lag = 4'h0;
		wr(8'h04, 8'h52);
		src(2'b10);
		`CHK(in_two, 1'b1)
		src(2'b11);
		`CHK(in_two, 1'b1)
		prio1 = 2'h1;
		prio2 = 2'h0;
		wr(8'h04, 8'h92);
		settle();
		`CHK(in_two, 1'b1)
		wr(8'h04, 8'hD2);
		src(2'b01);
		`CHK(in_two, 1'b1)
		`CHK(hold, 1'b0)
		// reserved priority codes never count as usable
		prio1 = 2'h3;
		prio2 = 2'h0;
		wr(8'h04, 8'h92);
		settle();
		`CHK({in_two, hold}, 2'h0)
		prio2 = 2'h2;
		settle();
		`CHK({in_two, hold}, 2'h1)
		done("automatic");
		do_reset();
		for (int a = 3; a < 6; a++) rd_chk(a[7:0]);
		done("second reset");
		close_out();
	end
endmodule
